// file: logic/lpmc_pkg.sv
package lpmc_pkg;

   // Core timer control/status field positions.
   localparam int CT_OVF_BIT = 7;
   localparam int CT_PER_BIT = 6;
   localparam int CT_OVFE_BIT = 5;
   localparam int CT_PERE_BIT = 4;
   localparam logic [7:0] CT_RESET_VAL = 8'h03;
   localparam logic [7:0] CT_SLEEP_CLR_MASK = 8'hF0;

   // Port widths and reset values.
   localparam int FIRST_PORT_W = 8;
   localparam int SECOND_PORT_W = 8;
   localparam int SHARED_PORT_W = 6;
   localparam logic [7:0] DIR_RESET_VAL = 8'h00;
   localparam logic [5:0] SHARED_RESET_VAL = 6'h00;
   localparam logic [7:0] PRESCALE_RESET_VAL = 8'h00;

   // Oscillator restart delay after a deep-sleep wake-up.
   localparam int CLK_PERIOD_NS = 50;
   localparam int OSC_STAB_NS = 200000;
   localparam int OSC_STAB_CYCLES = (OSC_STAB_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      LPMC_RUN = 4'h1,
      LPMC_LIGHT = 4'h2,
      LPMC_DEEP = 4'h4,
      LPMC_STAB = 4'h8
   } lpmc_state_t;

   // Wake sources, all active high.
   typedef struct packed {
      logic ext_irq;
      logic core_timer_irq;
      logic prog_timer_irq;
      logic serial_irq;
   } lpmc_wake_t;

   // Register writes from the CPU core.
   typedef struct packed {
      logic ct_we;
      logic [7:0] ct_wdata;
      logic dir_a_we;
      logic dir_b_we;
      logic conn_we;
      logic sel_we;
      logic pull_we;
      logic [7:0] wdata;
   } lpmc_wr_t;

   typedef struct packed {
      logic [7:0] dir_a;
      logic [7:0] dir_b;
      logic [5:0] conn;
      logic [5:0] sel;
      logic [5:0] pull_off;
   } lpmc_port_t;

endpackage

// file: logic/lpmc_stab_timer.sv
`timescale 1ns/10ps
`default_nettype none

// Counts the oscillator stabilization delay after a restart.
module lpmc_stab_timer #(
   parameter int CYCLES = lpmc_pkg::OSC_STAB_CYCLES
) (
   input wire logic clk_sys, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic ce, // Clock enable.
   input wire logic start, // Starts a new delay.
   output logic done // One-cycle pulse at the end of the delay.
);

   typedef struct packed {
      logic [$clog2(CYCLES+1)-1:0] cnt;
      logic busy;
      logic done;
   } lpmc_stab_st_t;

   lpmc_stab_st_t st_reg;
   lpmc_stab_st_t st_next;

   // The counter runs only while busy so a finished delay costs nothing.
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (start) begin
         st_next.busy = 1'b1;
         st_next.cnt = '0;
      end else if (st_reg.busy) begin
         if (st_reg.cnt == ($clog2(CYCLES+1))'(CYCLES - 1)) begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end
      end
   end

   // State register.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign done = st_reg.done;

endmodule // lpmc_stab_timer

`default_nettype wire

// file: logic/lpmc_ctrl.sv
//Function
//- Deep-sleep instruction stops oscillator, halting core timer and watchdog.
//- Entering deep sleep clears timer flags and both timer interrupt enables.
//- Entering deep sleep resets the core timer prescaler to zero.
//- Entering deep sleep clears the CPU interrupt mask bit.
//- Deep sleep keeps all other registers, timer bits and port states.
//- Only an external interrupt or reset ends deep sleep.
//- With deep sleep disabled by option, the instruction acts as no-operation.
//- Light sleep halts the CPU; timers and serial unit keep running.
//- Enabled core timer, 16-bit timer or serial interrupt ends light sleep.
//- Entering light sleep clears mask bit and keeps everything else.
//- Enabled core timer interrupt may wake light sleep periodically.
//- Reset makes all sixteen pins of the first two ports inputs.
//- Reset clears shared-port registers except data: inputs with pull-ups.
//- A set function-connect bit routes its pin to the alternate function.
//- Core timer register layout and reset value of binary 0000 0011.
`timescale 1ns/10ps
`default_nettype none

module lpmc_ctrl #(
   parameter int STAB_CYCLES = lpmc_pkg::OSC_STAB_CYCLES
) (
   input wire logic clk_sys, // System bus clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic ce, // Clock enable; low freezes all state.
   input wire logic deep_sleep_exec, // Deep-sleep instruction pulse.
   input wire logic light_sleep_exec, // Light-sleep instruction pulse.
   input wire logic deep_sleep_disable, // Factory option: deep sleep is a no-op.
   input wire logic set_irq_mask, // CPU sets its interrupt mask bit.
   input wire logic clr_irq_mask, // CPU clears its interrupt mask bit.
   input wire logic ext_irq_pin, // External interrupt request pin.
   input wire logic prog_timer_irq, // 16-bit timer interrupt request.
   input wire logic serial_irq, // Two-wire serial interrupt request.
   input wire logic ct_tick, // Core timer prescaler increment.
   input wire logic ct_overflow, // Core timer overflow event.
   input wire logic ct_periodic, // Periodic interrupt event.
   input wire lpmc_pkg::lpmc_wr_t wr, // Register writes from the core.
   output logic [7:0] core_timer_ctrl_status, // Core timer control/status.
   output logic [7:0] ct_prescale, // Core timer prescaler value.
   output logic irq_mask, // CPU interrupt mask bit.
   output logic osc_run, // Oscillator enable.
   output logic cpu_run, // CPU clock enable.
   output logic periph_run, // Timers and serial unit clock enable.
   output logic wake_vector, // Pulse: resume and take the interrupt.
   output lpmc_pkg::lpmc_port_t port_cfg, // Port direction and function setup.
   output logic [5:0] shared_port_function_connect, // Alternate routing.
   output logic [5:0] shared_port_function_select // Alternate selection.
);

   typedef struct packed {
      lpmc_pkg::lpmc_state_t state;
      logic [7:0] ct;
      logic [7:0] pre;
      logic mask;
      logic osc;
      logic cpu;
      logic periph;
      logic wake;
      logic stab_start;
      logic ext_s1;
      logic ext_s2;
      lpmc_pkg::lpmc_port_t port;
   } lpmc_st_t;

   lpmc_st_t st_reg;
   lpmc_st_t st_next;
   logic stab_done;
   logic light_wake;

   // Oscillator restart delay counter.
   lpmc_stab_timer #(
      .CYCLES(STAB_CYCLES)
   ) u_stab (
      .clk_sys(clk_sys),
      .srst(srst),
      .ce(ce),
      .start(st_reg.stab_start),
      .done(stab_done)
   );

   // A light-sleep wake needs an enabled source; the serial and 16-bit
   // timer requests arrive already gated by their own enables.
   assign light_wake = (st_reg.ct[lpmc_pkg::CT_OVF_BIT] &
                        st_reg.ct[lpmc_pkg::CT_OVFE_BIT]) |
                       (st_reg.ct[lpmc_pkg::CT_PER_BIT] &
                        st_reg.ct[lpmc_pkg::CT_PERE_BIT]) |
                       prog_timer_irq | serial_irq;

   // Next-state logic for the whole block.
   always_comb begin
      st_next = st_reg;
      st_next.wake = 1'b0;
      st_next.stab_start = 1'b0;
      st_next.ext_s1 = ext_irq_pin;
      st_next.ext_s2 = st_reg.ext_s1;

      // Mask bit: the sleep entries below override a CPU set.
      if (clr_irq_mask) begin
         st_next.mask = 1'b0;
      end else if (set_irq_mask) begin
         st_next.mask = 1'b1;
      end

      // Core timer runs only while peripherals are clocked.
      if (st_reg.periph) begin
         if (ct_tick) begin
            st_next.pre = st_reg.pre + 8'h01;
         end
         if (wr.ct_we) begin
            st_next.ct[5:4] = wr.ct_wdata[5:4];
            st_next.ct[1:0] = wr.ct_wdata[1:0];
            // Software clears a flag by writing zero; a new event wins.
            if (!wr.ct_wdata[7]) begin
               st_next.ct[7] = 1'b0;
            end
            if (!wr.ct_wdata[6]) begin
               st_next.ct[6] = 1'b0;
            end
         end
         if (ct_overflow) begin
            st_next.ct[lpmc_pkg::CT_OVF_BIT] = 1'b1;
         end
         if (ct_periodic) begin
            st_next.ct[lpmc_pkg::CT_PER_BIT] = 1'b1;
         end
      end

      // Port configuration writes; only honoured while the CPU runs.
      if (st_reg.cpu) begin
         if (wr.dir_a_we) begin
            st_next.port.dir_a = wr.wdata;
         end
         if (wr.dir_b_we) begin
            st_next.port.dir_b = wr.wdata;
         end
         if (wr.conn_we) begin
            st_next.port.conn = wr.wdata[5:0];
         end
         if (wr.sel_we) begin
            st_next.port.sel = wr.wdata[5:0];
         end
         if (wr.pull_we) begin
            st_next.port.pull_off = wr.wdata[5:0];
         end
      end

      case (st_reg.state)
         lpmc_pkg::LPMC_RUN: begin
            if (deep_sleep_exec && !deep_sleep_disable) begin
               st_next.state = lpmc_pkg::LPMC_DEEP;
               st_next.osc = 1'b0;
               st_next.cpu = 1'b0;
               st_next.periph = 1'b0;
               // Only flags and enables drop; rate bits stay.
               st_next.ct = st_reg.ct & ~lpmc_pkg::CT_SLEEP_CLR_MASK;
               st_next.pre = lpmc_pkg::PRESCALE_RESET_VAL;
               st_next.mask = 1'b0;
            end else if (light_sleep_exec) begin
               st_next.state = lpmc_pkg::LPMC_LIGHT;
               st_next.cpu = 1'b0;
               st_next.mask = 1'b0;
            end
         end
         lpmc_pkg::LPMC_LIGHT: begin
            // External interrupts also end light sleep.
            if (light_wake || st_reg.ext_s2) begin
               st_next.state = lpmc_pkg::LPMC_RUN;
               st_next.cpu = 1'b1;
               st_next.wake = 1'b1;
            end
         end
         lpmc_pkg::LPMC_DEEP: begin
            // Nothing internal runs here, so only the pin can wake.
            if (st_reg.ext_s2) begin
               st_next.state = lpmc_pkg::LPMC_STAB;
               st_next.osc = 1'b1;
               st_next.stab_start = 1'b1;
            end
         end
         lpmc_pkg::LPMC_STAB: begin
            if (stab_done) begin
               st_next.state = lpmc_pkg::LPMC_RUN;
               st_next.cpu = 1'b1;
               st_next.periph = 1'b1;
               st_next.wake = 1'b1;
            end
         end
         default: begin
            st_next.state = lpmc_pkg::LPMC_RUN;
         end
      endcase
   end

   // Reset covers power-on and the retention recovery, which the outside
   // world sequences by holding reset high across the supply dip.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st_reg.state <= lpmc_pkg::LPMC_RUN;
         st_reg.ct <= lpmc_pkg::CT_RESET_VAL;
         st_reg.pre <= lpmc_pkg::PRESCALE_RESET_VAL;
         st_reg.mask <= 1'b1;
         st_reg.osc <= 1'b1;
         st_reg.cpu <= 1'b1;
         st_reg.periph <= 1'b1;
         st_reg.wake <= 1'b0;
         st_reg.stab_start <= 1'b0;
         st_reg.ext_s1 <= 1'b0;
         st_reg.ext_s2 <= 1'b0;
         st_reg.port.dir_a <= lpmc_pkg::DIR_RESET_VAL;
         st_reg.port.dir_b <= lpmc_pkg::DIR_RESET_VAL;
         st_reg.port.conn <= lpmc_pkg::SHARED_RESET_VAL;
         st_reg.port.sel <= lpmc_pkg::SHARED_RESET_VAL;
         st_reg.port.pull_off <= lpmc_pkg::SHARED_RESET_VAL;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // Outputs come straight from the state register.
   assign core_timer_ctrl_status = st_reg.ct;
   assign ct_prescale = st_reg.pre;
   assign irq_mask = st_reg.mask;
   assign osc_run = st_reg.osc;
   assign cpu_run = st_reg.cpu;
   assign periph_run = st_reg.periph;
   assign wake_vector = st_reg.wake;
   assign port_cfg = st_reg.port;
   assign shared_port_function_connect = st_reg.port.conn;
   assign shared_port_function_select = st_reg.port.sel;

endmodule // lpmc_ctrl

`default_nettype wire

// file: dv/lpmc_irq_model.sv
`timescale 1ns/10ps
`default_nettype none

// Interrupt sources: a request stays up until the resume pulse, as a real
// source keeps asking until it is serviced.
module lpmc_irq_model (
   input wire logic clk_sys, // System clock.
   input wire logic srst, // Synchronous reset.
   input wire logic [2:0] raise, // Raise external, timer, serial.
   input wire logic wake_vector, // Resume pulse drops all requests.
   output logic ext_irq_pin, // External request.
   output logic prog_timer_irq, // Timer request, enable-gated.
   output logic serial_irq // Serial request, enable-gated.
);
   logic [2:0] req_reg;

   // Requests latch on a raise and clear at the resume.
   always_ff @(posedge clk_sys) begin
      if (srst || wake_vector) begin
         req_reg <= 3'h0;
      end else begin
         req_reg <= req_reg | raise;
      end
   end

   // Only enabled sources are ever raised.
   assign {ext_irq_pin, prog_timer_irq, serial_irq} = req_reg;
endmodule // lpmc_irq_model

`default_nettype wire

// file: dv/lpmc_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module lpmc_ctrl_assertions #(
   parameter int STAB_CYCLES = 4
) (
   input wire logic clk_sys, // Clock.
   input wire logic srst, // Reset.
   input wire logic deep_sleep_exec, // Deep request.
   input wire logic light_sleep_exec, // Light request.
   input wire logic deep_sleep_disable, // No-op option.
   input wire logic ext_irq_pin, // External request.
   input wire logic prog_timer_irq, // Timer request.
   input wire logic serial_irq, // Serial request.
   input wire logic [7:0] core_timer_ctrl_status, // Timer status.
   input wire logic [7:0] ct_prescale, // Prescaler.
   input wire logic irq_mask, // Mask bit.
   input wire logic osc_run, // Oscillator.
   input wire logic cpu_run, // CPU clock.
   input wire logic periph_run, // Peripheral clock.
   input wire logic wake_vector, // Resume pulse.
   input wire lpmc_pkg::lpmc_port_t port_cfg // Port setup.
);
   logic deep_go;
   logic light_go;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);

   // Entry only counts in run state; deep wins over light.
   assign deep_go = deep_sleep_exec && !deep_sleep_disable && cpu_run;
   assign light_go = light_sleep_exec && !deep_go && cpu_run;

   a_deep_stop: assert property (
      deep_go |=> !osc_run && !cpu_run && !periph_run)
      else $error("clocks still running in deep sleep");
   a_deep_clear: assert property (
      deep_go |=> core_timer_ctrl_status[7:4] == 4'h0 && ct_prescale == 8'h00)
      else $error("timer bits not cleared on deep entry");
   a_sleep_unmask: assert property (
      deep_go || light_go |=> !irq_mask)
      else $error("mask still set after sleep entry");
   a_deep_keep: assert property (
      !osc_run |=> $stable(port_cfg) && $stable(core_timer_ctrl_status[1:0]))
      else $error("state changed during deep sleep");
   a_deep_source: assert property (
      $rose(osc_run) && !$past(srst) |-> $past(ext_irq_pin, 2))
      else $error("deep sleep left without external request");
   a_deep_noop: assert property (
      deep_sleep_exec && deep_sleep_disable && !light_sleep_exec && cpu_run
      |=> cpu_run && osc_run)
      else $error("disabled deep sleep was not a no-op");
   a_light_enter: assert property (
      light_go |=> !cpu_run && periph_run && osc_run)
      else $error("light sleep entry wrong");
   a_light_wake: assert property (
      !cpu_run && periph_run && (prog_timer_irq || serial_irq)
      |=> cpu_run && wake_vector)
      else $error("light sleep did not end on request");
   a_stab_wait: assert property (
      $rose(osc_run) && !$past(srst)
      |-> !cpu_run [*3] ##[1:40] (cpu_run && wake_vector))
      else $error("no settled resume after oscillator restart");
   a_reset_state: assert property (
      disable iff (1'b0) srst |=> core_timer_ctrl_status == 8'h03
      && port_cfg == '0 && irq_mask && osc_run && cpu_run)
      else $error("reset state wrong");
endmodule // lpmc_ctrl_assertions

bind lpmc_ctrl lpmc_ctrl_assertions #(.STAB_CYCLES(STAB_CYCLES)) u_chk (
   .clk_sys(clk_sys), .srst(srst), .deep_sleep_exec(deep_sleep_exec),
   .light_sleep_exec(light_sleep_exec),
   .deep_sleep_disable(deep_sleep_disable), .ext_irq_pin(ext_irq_pin),
   .prog_timer_irq(prog_timer_irq), .serial_irq(serial_irq),
   .core_timer_ctrl_status(core_timer_ctrl_status),
   .ct_prescale(ct_prescale), .irq_mask(irq_mask), .osc_run(osc_run),
   .cpu_run(cpu_run), .periph_run(periph_run),
   .wake_vector(wake_vector), .port_cfg(port_cfg));

`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic deep_sleep_exec, light_sleep_exec, deep_sleep_disable;
   logic ct_tick, ct_overflow, irq_mask, osc_run, cpu_run, periph_run;
   logic wake_vector, ext_irq_pin, prog_timer_irq, serial_irq;
   logic [2:0] raise;
   logic [7:0] ct_st, pre;
   logic [5:0] conn, sel;
   lpmc_pkg::lpmc_wr_t wr;
   lpmc_pkg::lpmc_port_t port_cfg;
   logic [31:0] seed = 32'h00000038;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int exp_ct = 3;
   int port_d = 0;

   lpmc_ctrl #(.STAB_CYCLES(4)) i_dut (
      .clk_sys(clk_sys), .srst(srst), .ce(1'b1),
      .deep_sleep_exec(deep_sleep_exec), .light_sleep_exec(light_sleep_exec),
      .deep_sleep_disable(deep_sleep_disable), .set_irq_mask(1'b0),
      .clr_irq_mask(1'b0), .ext_irq_pin(ext_irq_pin),
      .prog_timer_irq(prog_timer_irq), .serial_irq(serial_irq),
      .ct_tick(ct_tick), .ct_overflow(ct_overflow), .ct_periodic(1'b0),
      .wr(wr), .core_timer_ctrl_status(ct_st), .ct_prescale(pre),
      .irq_mask(irq_mask), .osc_run(osc_run), .cpu_run(cpu_run),
      .periph_run(periph_run), .wake_vector(wake_vector),
      .port_cfg(port_cfg), .shared_port_function_connect(conn),
      .shared_port_function_select(sel));

   lpmc_irq_model i_src (
      .clk_sys(clk_sys), .srst(srst), .raise(raise),
      .wake_vector(wake_vector), .ext_irq_pin(ext_irq_pin),
      .prog_timer_irq(prog_timer_irq), .serial_irq(serial_irq));

   // Clock and a cycle ceiling so that a hang still reaches the verdict.
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Inputs change only at the falling edge.
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic wr_ports(input logic [7:0] d);
      wr.wdata = d;
      {wr.dir_a_we, wr.dir_b_we, wr.conn_we, wr.sel_we, wr.pull_we} = 5'h1F;
      cyc(1);
      wr = '0;
      port_d = d;
      chk({port_cfg.dir_a, port_cfg.dir_b, port_cfg.sel}, {d, d, d[5:0]});
      chk({conn, port_cfg.conn}, {2{d[5:0]}});
   endtask

   // Flags clear only where a zero is written; enables and rate load.
   task automatic wr_ct(input logic [7:0] d);
      wr.ct_we = 1'b1;
      wr.ct_wdata = d;
      cyc(1);
      wr = '0;
      exp_ct = (exp_ct & d & 8'hC0) | (d & 8'h33);
      chk(ct_st, exp_ct);
   endtask

   task automatic wait_wake(input int lim);
      int i;
      i = 0;
      while (wake_vector !== 1'b1 && i < lim) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      chk({wake_vector, cpu_run}, 2'h3);
   endtask

   task automatic enter(input logic deep);
      deep_sleep_exec = deep;
      light_sleep_exec = !deep;
      cyc(1);
      {deep_sleep_exec, light_sleep_exec} = 2'h0;
   endtask

   initial begin
      logic [31:0] r;
      {deep_sleep_exec, light_sleep_exec, deep_sleep_disable} = 3'h0;
      {ct_tick, ct_overflow, raise} = 5'h00;
      wr = '0;
      cyc(16);
      srst = 1'b0;
      chk(ct_st, 8'h03);
      chk({port_cfg.dir_a, port_cfg.dir_b, port_cfg.conn, port_cfg.sel}, 32'h0);
      chk({port_cfg.pull_off, conn, sel}, 32'h0);
      repeat (3) begin
         r = xs();
         wr_ports(r[7:0]);
      end
      r = xs();
      wr_ct(r[7:0]);
      wr_ct(8'h33);
      r = xs() % 5 + 1;
      ct_tick = 1'b1;
      cyc(r);
      ct_tick = 1'b0;
      chk(pre, r);
      deep_sleep_disable = 1'b1;
      enter(1'b1);
      deep_sleep_disable = 1'b0;
      chk({cpu_run, osc_run, irq_mask}, 3'h7);
      enter(1'b1);
      exp_ct = exp_ct & 8'h0F;
      chk({osc_run, cpu_run, periph_run, irq_mask}, 4'h0);
      chk({ct_st, pre}, exp_ct << 8);
      raise = 3'h3;
      ct_tick = 1'b1;
      cyc(8);
      {raise, ct_tick} = 4'h0;
      chk({osc_run, cpu_run, pre}, 10'h0);
      chk({port_cfg.dir_a, ct_st}, {port_d[7:0], exp_ct[7:0]});
      raise = 3'h4;
      cyc(1);
      raise = 3'h0;
      wait_wake(40);
      cyc(4);
      wr_ct(8'h20);
      for (int k = 0; k < 3; k++) begin
         enter(1'b0);
         chk({cpu_run, periph_run, irq_mask}, 3'h2);
         cyc(xs() % 4 + 1);
         raise = 3'h2 >> k;
         ct_overflow = (k == 2);
         cyc(1);
         {raise, ct_overflow} = 4'h0;
         wait_wake(6);
         cyc(3);
      end
      enter(1'b1);
      srst = 1'b1;
      cyc(4);
      srst = 1'b0;
      chk({ct_st, pre, port_cfg.dir_a}, 24'h030000);
      chk({osc_run, cpu_run, irq_mask}, 3'h7);
      complete_run();
   end
endmodule // tb

`default_nettype wire
